// [hw/mcswg_top.sv]
/*
 * memory chip select and wait generator: register file on the core's
 * i/o write/read strobes, rom/ram select decode and chip select waits.
 * assumes all inputs come from core logic on the same 20 MHz clock, so
 * none is synchronised; strobes are one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module mcswg_top (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // register access from the core
    input  wire mcswg_pkg::mcswg_reg_req_s     reg_req,
    output logic      [7:0]                    reg_rdata,
    // memory bus from the core
    input  wire mcswg_pkg::mcswg_mem_bus_s     mem_bus,
    input  wire logic [mcswg_pkg::WCOUNT_W-1:0] core_wait_count,
    // selects and wait
    output logic                               rom_select_n,
    output logic                               ram_select_n,
    output logic                               wait_n
);
    import mcswg_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] chip_select_wait_control;
    logic [7:0] rom_region_upper_bound;
    logic [7:0] ram_region_upper_bound;
    logic [7:0] ram_region_lower_bound;
    logic [7:0] system_config;

    always_ff @(posedge clk) begin
        if (rst) begin
            rom_region_upper_bound <= RST_BOUND;
            ram_region_upper_bound <= RST_BOUND;
            ram_region_lower_bound <= RST_BOUND;
        end else if (reg_req.wr) begin
            if (reg_req.addr == OFS_ROM_REGION_UPPER_BOUND) begin
                rom_region_upper_bound <= reg_req.wdata;
            end
            if (reg_req.addr == OFS_RAM_REGION_UPPER_BOUND) begin
                ram_region_upper_bound <= reg_req.wdata;
            end
            if (reg_req.addr == OFS_RAM_REGION_LOWER_BOUND) begin
                ram_region_lower_bound <= reg_req.wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            chip_select_wait_control <= RST_WAIT_CTRL;
            system_config            <= RST_SYS_CONFIG;
        end else if (reg_req.wr) begin
            if (reg_req.addr == OFS_CHIP_SELECT_WAIT_CONTROL) begin
                chip_select_wait_control <= reg_req.wdata;
            end
            if (reg_req.addr == OFS_SYSTEM_CONFIG) begin
                system_config <= reg_req.wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // register read, one cycle after the strobe
    // ----------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb begin
        unique case (reg_req.addr)
            OFS_CHIP_SELECT_WAIT_CONTROL: next_rdata = chip_select_wait_control;
            OFS_RAM_REGION_UPPER_BOUND:   next_rdata = ram_region_upper_bound;
            OFS_RAM_REGION_LOWER_BOUND:   next_rdata = ram_region_lower_bound;
            OFS_ROM_REGION_UPPER_BOUND:   next_rdata = rom_region_upper_bound;
            OFS_SYSTEM_CONFIG:            next_rdata = system_config;
            default:                      next_rdata = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= UNMAPPED_READ;
        end else if (reg_req.rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // select decode
    // ----------------------------------------------------------------
    logic rom_hit;
    logic ram_hit;
    logic select_ok;

    // the page is the core's own address, bit 18 included, never the
    // pin that the timer output shares
    mcswg_decode u_decode (
        .page            (mem_bus.addr[PAGE_MSB:PAGE_LSB]),
        .rom_upper_bound (rom_region_upper_bound),
        .ram_upper_bound (ram_region_upper_bound),
        .ram_lower_bound (ram_region_lower_bound),
        .rom_overlay     (system_config[ROM_OVERLAY_BIT]),
        .rom_hit         (rom_hit),
        .ram_hit         (ram_hit)
    );

    // refresh cycles also pulse the memory request, so they are masked
    assign select_ok = !mem_bus.memory_request_n && mem_bus.refresh_n
                       && !mem_bus.halted;

    always_ff @(posedge clk) begin
        if (rst) begin
            rom_select_n <= 1'b1;
            ram_select_n <= 1'b1;
        end else begin
            rom_select_n <= !(select_ok && rom_hit);
            ram_select_n <= !(select_ok && ram_hit);
        end
    end

    // ----------------------------------------------------------------
    // chip select wait generator
    // ----------------------------------------------------------------
    logic                request_seen;
    logic                access_start;
    logic [WCOUNT_W-1:0] rom_waits;
    logic [WCOUNT_W-1:0] ram_waits;
    logic [WCOUNT_W-1:0] cs_waits;
    logic [WCOUNT_W-1:0] total_waits;
    logic [WCOUNT_W-1:0] wait_left;

    always_ff @(posedge clk) begin
        if (rst) begin
            request_seen <= 1'b0;
        end else begin
            request_seen <= select_ok;
        end
    end

    assign access_start = select_ok && !request_seen;

    // a three-bit field n means n + 1 waits
    assign rom_waits = {1'b0, chip_select_wait_control[ROM_WAIT_LSB +: WAIT_FIELD_W]} + WAIT_ONE;
    assign ram_waits = {1'b0, chip_select_wait_control[RAM_WAIT_LSB +: WAIT_FIELD_W]} + WAIT_ONE;

    always_comb begin
        cs_waits = WAIT_NONE;
        if (rom_hit && chip_select_wait_control[ROM_WAIT_EN_BIT]) begin
            cs_waits = rom_waits;
        end else if (ram_hit && chip_select_wait_control[RAM_WAIT_EN_BIT]) begin
            cs_waits = ram_waits;
        end
    end

    // the core's own generator still runs; the longer demand wins, which
    // is why software is told to set the core's demand to zero
    assign total_waits = (core_wait_count > cs_waits) ? core_wait_count : cs_waits;

    mcswg_wait_count u_wait (
        .clk   (clk),
        .rst   (rst),
        .start (access_start),
        .load  (total_waits),
        .count (wait_left)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            wait_n <= 1'b1;
        end else begin
            wait_n <= !((access_start && total_waits != WAIT_NONE) || wait_left > WAIT_ONE);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_ram_access;
        select_ok && ram_hit;
    endsequence

    sequence s_start_n(logic [WCOUNT_W-1:0] n);
        access_start && total_waits == n;
    endsequence

    a_rom_priority: assert property (@(posedge clk) disable iff (rst)
        !rom_select_n |-> ram_select_n)
        else $error("ram select asserted together with rom select");

    a_ram_window: assert property (@(posedge clk) disable iff (rst)
        s_ram_access |=> !ram_select_n)
        else $error("ram select missed an in-range access");

    a_rom_window: assert property (@(posedge clk) disable iff (rst)
        (select_ok && mem_bus.addr[PAGE_MSB:PAGE_LSB] <= rom_region_upper_bound
         && !system_config[ROM_OVERLAY_BIT]) |=> !rom_select_n)
        else $error("rom select missed an in-range access");

    a_overlay_force: assert property (@(posedge clk) disable iff (rst)
        system_config[ROM_OVERLAY_BIT] |=> rom_select_n)
        else $error("rom select asserted while overlay forced");

    a_halt_deselect: assert property (@(posedge clk) disable iff (rst)
        mem_bus.halted |=> rom_select_n && ram_select_n)
        else $error("select asserted during sleep or halt");

    a_non_memory_idle: assert property (@(posedge clk) disable iff (rst)
        (mem_bus.memory_request_n || !mem_bus.refresh_n) |=> rom_select_n && ram_select_n)
        else $error("select asserted outside a memory request");

    a_reset_values: assert property (@(posedge clk)
        rst |=> rom_region_upper_bound == RST_BOUND && ram_region_lower_bound == RST_BOUND
                && ram_region_upper_bound == RST_BOUND && chip_select_wait_control == RST_WAIT_CTRL)
        else $error("register reset value wrong");

    a_wait_max: assert property (@(posedge clk) disable iff (rst)
        access_start |-> total_waits >= core_wait_count && total_waits >= cs_waits)
        else $error("wait count is not the larger demand");

    a_eight_waits: assert property (@(posedge clk) disable iff (rst)
        s_start_n(4'h8) |=> !wait_n [*8] ##1 wait_n)
        else $error("eight-wait access did not hold wait for eight cycles");

    a_one_wait: assert property (@(posedge clk) disable iff (rst)
        s_start_n(4'h1) |=> !wait_n ##1 wait_n)
        else $error("one-wait access length wrong");

    // ----------------------------------------------------------------
    // wait run length and further select and wait checks
    // ----------------------------------------------------------------
    // saturating, so a stuck wait cannot wrap back into the legal range
    logic [WCOUNT_W:0] wait_run;

    always_ff @(posedge clk) begin
        if (rst) begin
            wait_run <= '0;
        end else if (wait_n) begin
            wait_run <= '0;
        end else if (wait_run != '1) begin
            wait_run <= wait_run + 5'h01;
        end
    end

    sequence s_rom_wait_on;
        access_start && rom_hit && chip_select_wait_control[ROM_WAIT_EN_BIT];
    endsequence

    sequence s_ram_wait_on;
        access_start && ram_hit && chip_select_wait_control[RAM_WAIT_EN_BIT];
    endsequence

    a_rom_field_floor: assert property (@(posedge clk) disable iff (rst)
        s_rom_wait_on |-> total_waits > {1'b0, chip_select_wait_control[ROM_WAIT_LSB +: WAIT_FIELD_W]})
        else $error("rom wait shorter than its field asks");

    a_ram_field_floor: assert property (@(posedge clk) disable iff (rst)
        s_ram_wait_on |-> total_waits > {1'b0, chip_select_wait_control[RAM_WAIT_LSB +: WAIT_FIELD_W]})
        else $error("ram wait shorter than its field asks");

    a_waits_off: assert property (@(posedge clk) disable iff (rst)
        (access_start && !(rom_hit && chip_select_wait_control[ROM_WAIT_EN_BIT])
         && !(ram_hit && chip_select_wait_control[RAM_WAIT_EN_BIT])) |-> total_waits == core_wait_count)
        else $error("disabled select waits changed the core demand");

    a_zero_wait: assert property (@(posedge clk) disable iff (rst)
        s_start_n(WAIT_NONE) |=> wait_n [*2])
        else $error("wait asserted on an access with no demand");

    a_four_waits: assert property (@(posedge clk) disable iff (rst)
        s_start_n(4'h4) |=> !wait_n [*4] ##1 wait_n)
        else $error("four-wait access did not hold wait for four cycles");

    a_wait_bounded: assert property (@(posedge clk) disable iff (rst)
        wait_run <= {1'b0, {WCOUNT_W{1'b1}}})
        else $error("wait held longer than the largest demand");

    a_ram_outside: assert property (@(posedge clk) disable iff (rst)
        (select_ok && (mem_bus.addr[PAGE_MSB:PAGE_LSB] > ram_region_upper_bound
         || mem_bus.addr[PAGE_MSB:PAGE_LSB] < ram_region_lower_bound)) |=> ram_select_n)
        else $error("ram select asserted outside its window");

    a_rom_above: assert property (@(posedge clk) disable iff (rst)
        (mem_bus.addr[PAGE_MSB:PAGE_LSB] > rom_region_upper_bound) |=> rom_select_n)
        else $error("rom select asserted above its bound");

    a_idle_no_wait: assert property (@(posedge clk) disable iff (rst)
        (!access_start && wait_left <= WAIT_ONE) |=> wait_n)
        else $error("wait asserted with no count left");

endmodule : mcswg_top
`default_nettype wire

// [hw/mcswg_pkg.sv]
/*
 * constants, register offsets, reset values and carrier types for the
 * memory chip select and wait generator.
 * assumes one 20 MHz system clock shared with the processor core.
 */
`default_nettype none
package mcswg_pkg;

    // ----------------------------------------------------------------
    // register offsets (low eight bits of the i/o address)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CHIP_SELECT_WAIT_CONTROL = 8'hD8;
    localparam logic [7:0] OFS_RAM_REGION_UPPER_BOUND   = 8'hE6;
    localparam logic [7:0] OFS_RAM_REGION_LOWER_BOUND   = 8'hE7;
    localparam logic [7:0] OFS_ROM_REGION_UPPER_BOUND   = 8'hE8;
    localparam logic [7:0] OFS_SYSTEM_CONFIG            = 8'hEF;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_BOUND      = 8'hFF;
    localparam logic [7:0] RST_WAIT_CTRL  = 8'h77;
    localparam logic [7:0] RST_SYS_CONFIG = 8'h00;
    localparam logic [7:0] UNMAPPED_READ  = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int RAM_WAIT_EN_BIT  = 7;
    localparam int RAM_WAIT_LSB     = 4;
    localparam int ROM_WAIT_EN_BIT  = 3;
    localparam int ROM_WAIT_LSB     = 0;
    localparam int WAIT_FIELD_W     = 3;
    localparam int ROM_OVERLAY_BIT  = 3;
    localparam int PAGE_MSB         = 19;
    localparam int PAGE_LSB         = 12;

    // ----------------------------------------------------------------
    // timing and widths
    // ----------------------------------------------------------------
    localparam int ADDR_W   = 20;
    localparam int WCOUNT_W = 4;
    localparam logic [WCOUNT_W-1:0] WAIT_ONE  = 4'h1;
    localparam logic [WCOUNT_W-1:0] WAIT_NONE = 4'h0;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              memory_request_n;
        logic              refresh_n;
        logic              halted;
    } mcswg_mem_bus_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcswg_reg_req_s;

endpackage : mcswg_pkg
`default_nettype wire

// [hw/mcswg_decode.sv]
/*
 * address window compare for the rom and ram selects, combinational.
 * assumes the caller qualifies the hits with the memory request.
 */
`timescale 1ns/1ps
`default_nettype none
module mcswg_decode (
    // page and bounds
    input  wire logic [7:0] page,
    input  wire logic [7:0] rom_upper_bound,
    input  wire logic [7:0] ram_upper_bound,
    input  wire logic [7:0] ram_lower_bound,
    input  wire logic       rom_overlay,
    // hits
    output logic            rom_hit,
    output logic            ram_hit
);
    import mcswg_pkg::*;

    logic rom_in;
    logic ram_in;

    // rom floor is page zero, so only the ceiling needs a compare
    assign rom_in  = (page <= rom_upper_bound) && !rom_overlay;
    assign ram_in  = (page <= ram_upper_bound) && (page >= ram_lower_bound);
    assign rom_hit = rom_in;
    assign ram_hit = ram_in && !rom_in;

endmodule : mcswg_decode
`default_nettype wire

// [hw/mcswg_wait_count.sv]
/*
 * down counter that holds the wait request for a loaded number of cycles.
 * assumes start is a one-cycle pulse at the opening of an access.
 */
`timescale 1ns/1ps
`default_nettype none
module mcswg_wait_count (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // control
    input  wire logic                          start,
    input  wire logic [mcswg_pkg::WCOUNT_W-1:0] load,
    // state
    output logic      [mcswg_pkg::WCOUNT_W-1:0] count
);
    import mcswg_pkg::*;

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= WAIT_NONE;
        end else if (start) begin
            count <= load;
        end else if (count != WAIT_NONE) begin
            count <= count - WAIT_ONE;
        end
    end

endmodule : mcswg_wait_count
`default_nettype wire

// [tb/mcswg_core_model.sv]
/*
 * model of the processor core's memory bus: one access per call of access,
 * held through the waits the block asks for, then released for a cycle.
 * assumes the bench calls access from one thread; inputs move at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
module mcswg_core_model (
    // clock
    input  wire logic                           clk,
    // selects and wait from the block
    input  wire logic                           rom_select_n,
    input  wire logic                           ram_select_n,
    input  wire logic                           wait_n,
    // memory bus to the block
    output var  mcswg_pkg::mcswg_mem_bus_s      mem_bus,
    output var  logic [mcswg_pkg::WCOUNT_W-1:0] core_wait_count
);
    import mcswg_pkg::*;

    initial begin
        mem_bus = '{addr: 20'h00000, memory_request_n: 1'b1, refresh_n: 1'b1, halted: 1'b0};
        core_wait_count = 4'h0;
    end

    // kind: 0 memory, 1 i/o, 2 refresh only, 3 halted
    task automatic access(input logic [19:0] a, input logic [3:0] cw, input logic [1:0] kind,
                          output logic [1:0] sel, output logic [7:0] waits);
        @(negedge clk);
        mem_bus = '{addr: a, memory_request_n: (kind == 2'h1), refresh_n: (kind != 2'h2),
                    halted: (kind == 2'h3)};
        core_wait_count = cw;
        @(negedge clk);
        sel = {rom_select_n, ram_select_n};
        waits = 8'h00;
        // request held through the longest possible wait (15)
        repeat (20) begin
            if (wait_n === 1'b0) waits = waits + 8'h01;
            @(negedge clk);
        end
        // released address lines show the inverse, never a stale copy
        mem_bus = '{addr: ~a, memory_request_n: 1'b1, refresh_n: 1'b1, halted: 1'b0};
    endtask : access
endmodule : mcswg_core_model
`default_nettype wire

// [tb/tb.sv]
/*
 * self-checking bench for the chip select and wait generator: register
 * reads and writes, a wait field sweep and random decode with boundary pages.
 * assumes the design's own assertions run alongside; 20 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mcswg_pkg::*;
    logic                clk;
    logic                rst;
    mcswg_reg_req_s      reg_req;
    mcswg_mem_bus_s      mem_bus;
    logic [7:0]          reg_rdata;
    logic [WCOUNT_W-1:0] core_wait_count;
    logic                rom_select_n;
    logic                ram_select_n;
    logic                wait_n;
    logic [31:0]         seed = 32'h3345;
    int                  n_errors = 0;
    int                  compares = 0;
    // bench copies of the programmed registers
    logic [7:0]          rom_bound = 8'hFF, ramu = 8'hFF, raml = 8'hFF, wctl = 8'h77, sysc = 8'h00;

    mcswg_top dut_u (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .mem_bus(mem_bus),
                     .core_wait_count(core_wait_count), .rom_select_n(rom_select_n),
                     .ram_select_n(ram_select_n), .wait_n(wait_n));
    mcswg_core_model core_u (.clk(clk), .rom_select_n(rom_select_n), .ram_select_n(ram_select_n),
                             .wait_n(wait_n), .mem_bus(mem_bus), .core_wait_count(core_wait_count));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // {waits, rom_select_n, ram_select_n} expected for one access
    function automatic logic [9:0] exp_acc(input logic [19:0] a, input logic [3:0] cw, input logic [1:0] kind);
        logic       rh;
        logic       mh;
        logic [3:0] cs;
        logic [3:0] tot;
        rh = (kind == 2'h0) && !sysc[3] && (a[19:12] <= rom_bound);
        mh = (kind == 2'h0) && !rh && (a[19:12] >= raml) && (a[19:12] <= ramu);
        cs = (rh && wctl[3]) ? {1'b0, wctl[2:0]} + 4'h1 : (mh && wctl[7]) ? {1'b0, wctl[6:4]} + 4'h1 : 4'h0;
        tot = (kind != 2'h0) ? 4'h0 : ((cw > cs) ? cw : cs);
        return {4'h0, tot, ~rh, ~mh};
    endfunction : exp_acc

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        reg_req.wr = 1'b0;
    endtask : reg_wr

    task automatic reg_rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        reg_req.rd = 1'b0;
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask : reg_rd_chk

    task automatic do_access(input logic [19:0] a, input logic [3:0] cw, input logic [1:0] kind);
        logic [1:0] sel;
        logic [7:0] waits;
        logic [9:0] e;
        e = exp_acc(a, cw, kind);
        core_u.access(a, cw, kind, sel, waits);
        chk({6'h00, sel}, {6'h00, e[1:0]});
        chk(waits, e[9:2]);
    endtask : do_access

    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [31:0] s;
        logic [7:0]  pg;
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        reg_rd_chk(OFS_CHIP_SELECT_WAIT_CONTROL, 8'h77);
        reg_rd_chk(OFS_RAM_REGION_UPPER_BOUND, 8'hFF);
        reg_rd_chk(OFS_RAM_REGION_LOWER_BOUND, 8'hFF);
        reg_rd_chk(OFS_ROM_REGION_UPPER_BOUND, 8'hFF);
        reg_rd_chk(OFS_SYSTEM_CONFIG, 8'h00);
        reg_wr(8'hD9, 8'h5A);
        reg_rd_chk(8'hD9, 8'h00);
        // top page still goes to rom while the bounds sit at reset
        do_access(20'hFF123, 4'h0, 2'h0);
        $display("test reset_values done");
        for (int n = 0; n < 8; n++) begin
            wctl = {1'b1, n[2:0], 1'b1, n[2:0]};
            reg_wr(OFS_CHIP_SELECT_WAIT_CONTROL, wctl);
            do_access(20'h00000, 4'h0, 2'h0);
        end
        $display("test wait_sweep done");
        repeat (60) begin
            r = xs();
            s = xs();
            {raml, ramu, rom_bound} = r[23:0];
            wctl = s[7:0];
            sysc = s[15:8];
            reg_wr(OFS_ROM_REGION_UPPER_BOUND, rom_bound);
            reg_wr(OFS_RAM_REGION_UPPER_BOUND, ramu);
            reg_wr(OFS_RAM_REGION_LOWER_BOUND, raml);
            reg_wr(OFS_CHIP_SELECT_WAIT_CONTROL, wctl);
            reg_wr(OFS_SYSTEM_CONFIG, sysc);
            reg_rd_chk(OFS_RAM_REGION_LOWER_BOUND, raml);
            reg_rd_chk(OFS_CHIP_SELECT_WAIT_CONTROL, wctl);
            // boundary pages on either side of each bound, else random
            case (s[18:16])
                3'h0: pg = rom_bound;
                3'h1: pg = rom_bound + 8'h01;
                3'h2: pg = raml;
                3'h3: pg = raml - 8'h01;
                3'h4: pg = ramu;
                3'h5: pg = ramu + 8'h01;
                default: pg = s[31:24];
            endcase
            do_access({pg, r[31:24], s[22:19]}, r[27:24], s[23] ? 2'h0 : r[29:28]);
        end
        $display("test random_decode done");
        test_done();
    end

    initial begin
        #1000000;
        n_errors++;
        test_done();
    end
endmodule : tb
`default_nettype wire
